/* tb/jtag_host.sv */
// Test host model that drives the test pins of the chain
`timescale 1ns/1ps
module jtag_host (
  // Clock
  input wire logic ref_clk,
  // Test pins
  output tap_chain_pkg::jtag_pins_t jtag,
  input wire logic tdo_out,
  input wire logic tdo_oe_n
);
  logic tdo_last;
  logic tdo_pin;

  // ----------------------------------------------------------------
  // Data out line
  // ----------------------------------------------------------------
  // Released line shows the inverse of the last driven bit
  assign tdo_pin = tdo_oe_n ? ~tdo_last : tdo_out;

  initial begin
    jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b0};
    tdo_last = 1'b0;
  end

  always @(posedge ref_clk) begin
    if (!tdo_oe_n) begin
      tdo_last <= tdo_out;
    end
  end

  // ----------------------------------------------------------------
  // Pin sequences
  // ----------------------------------------------------------------
  // One 400 ns period: fall, set inputs, rise, sample before next fall
  task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
    @(posedge ref_clk);
    jtag.tck <= 1'b0;
    jtag.tms <= tms;
    jtag.tdi <= tdi;
    repeat (4) @(posedge ref_clk);
    jtag.tck <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    tdo = tdo_pin;
    oe_n = tdo_oe_n;
  endtask

  // Test reset low for the given count of 50 ns reference cycles, then released
  task automatic test_reset(input int cycles);
    @(posedge ref_clk);
    jtag.trst_n <= 1'b0;
    jtag.tck <= 1'b0;
    repeat (cycles) @(posedge ref_clk);
    jtag.trst_n <= 1'b1;
  endtask

  // Idle to shift state, n bits lsb first, then update and back to idle
  task automatic scan(input bit ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout, output logic oe_any);
    logic t;
    logic o;
    dout = '0;
    oe_any = 1'b0;
    step(1'b1, 1'b0, t, o);
    if (ir) begin
      step(1'b1, 1'b0, t, o);
    end
    step(1'b0, 1'b0, t, o);
    step(1'b0, 1'b0, t, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], t, o);
      dout[i] = t;
      oe_any = oe_any | o;
    end
    step(1'b1, ~din[n-1], t, o);
    step(1'b0, ~din[n-1], t, o);
  endtask
endmodule

/* tb/tap_chain_bench.sv */
// Self-checking bench for the test port chain
`timescale 1ns/1ps
module tap_chain_bench;
  localparam logic [3:0] VER = 4'h3;
  localparam logic [15:0] PB = 16'h0a51; // arbitrary value
  localparam logic [15:0] PC = 16'h0b62; // arbitrary value
  localparam logic [10:0] MK = 11'h2c5; // arbitrary value
  localparam logic [15:0] REV = 16'h00c7; // arbitrary value
  localparam logic [31:0] ID_B = {VER, PB, MK, 1'b1};
  localparam logic [31:0] ID_C = {VER, PC, MK, 1'b1};
  localparam logic [63:0] D = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] BYP = {D[61:0], 2'b00};
  localparam logic [31:0] RD = 32'hc3a5_0f69;
  localparam logic [31:0] OTP = 32'h5a0f_3c96;
  localparam logic [7:0] PIN = 8'hb4;
  localparam logic [31:0] SEC_U = 32'ha940_2001;

  typedef struct packed {
    logic [7:0] ir;
    logic [31:0] sec;
    logic [63:0] exp;
    logic tile_wr;
    logic otp_wr;
  } row_t;

  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  tap_chain_pkg::jtag_pins_t jtag;
  logic tdo_out;
  logic tdo_oe_n;
  logic [31:0] sec_reg = 32'h0;
  logic [7:0] pin_out;
  logic pin_drive;
  logic [31:0] tile_wr_data;
  logic tile_wr_stb;
  logic otp_wr_stb;
  int failures = 0;
  int samples_checked = 0;
  int tile_cnt = 0;
  int otp_cnt = 0;
  row_t rows [10];
  logic [63:0] q;
  logic oe;
  logic t;

  always #25 ref_clk = ~ref_clk;

  tap_chain #(.TILES(1), .BSR_LEN(8), .VERSION(VER), .PART_BSCAN(PB), .PART_CHIP(PC),
              .MAKER(MK), .SIL_REV(REV)) tap_chain_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .jtag(jtag), .tdo_out(tdo_out),
    .tdo_oe_n(tdo_oe_n), .sec_reg(sec_reg), .pin_in(PIN), .pin_out(pin_out),
    .pin_drive(pin_drive), .tile_rd_data(RD), .tile_wr_data(tile_wr_data),
    .tile_wr_stb(tile_wr_stb), .otp_rd_data(OTP), .otp_wr_stb(otp_wr_stb));

  jtag_host jtag_host_i (.ref_clk(ref_clk), .jtag(jtag), .tdo_out(tdo_out),
                         .tdo_oe_n(tdo_oe_n));

  always @(posedge ref_clk) begin
    if (tile_wr_stb === 1'b1) begin
      tile_cnt <= tile_cnt + 1;
    end
    if (otp_wr_stb === 1'b1) begin
      otp_cnt <= otp_cnt + 1;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] uc(input logic [9:0] u);
    return {u, 6'h00, REV};
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic run_row(input row_t r);
    int t0;
    int o0;
    t0 = tile_cnt;
    o0 = otp_cnt;
    @(posedge ref_clk);
    sec_reg <= r.sec;
    jtag_host_i.scan(1'b1, 8, {56'h0, r.ir}, q, oe);
    check(q, 64'h11);
    jtag_host_i.scan(1'b0, 64, D, q, oe);
    check(q, r.exp);
    check({63'h0, oe}, 64'h0);
    check({63'h0, tdo_oe_n}, 64'h1);
    // Strobe lands after the update rise is seen, then gets counted
    repeat (2) @(negedge ref_clk);
    check(64'(tile_cnt - t0), {63'h0, r.tile_wr});
    check(64'(otp_cnt - o0), {63'h0, r.otp_wr});
    if (r.tile_wr || r.otp_wr) begin
      check({32'h0, tile_wr_data}, {32'h0, D[62:31]});
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge ref_clk);
    failures++;
    end_of_test();
  end

  initial begin
    rows[0] = '{8'h11, 32'h0, {ID_B, ID_C}, 1'b0, 1'b0};
    rows[1] = '{8'h22, 32'h0, {uc(10'h000), uc(10'h000)}, 1'b0, 1'b0};
    rows[2] = '{8'h22, SEC_U, {uc(SEC_U[31:22]), uc(SEC_U[31:22])}, 1'b0, 1'b0};
    rows[3] = '{8'hff, 32'h0, BYP, 1'b0, 1'b0};
    rows[4] = '{8'hf8, 32'h0, {D[30:0], 1'b0, RD}, 1'b1, 1'b0};
    rows[5] = '{8'hf8, 32'h1, BYP, 1'b0, 1'b0};
    rows[6] = '{8'hf9, 32'h0, {D[30:0], 1'b0, OTP}, 1'b0, 1'b1};
    rows[7] = '{8'hf9, 32'h2000, BYP, 1'b0, 1'b0};
    rows[8] = '{8'h3f, 32'h0, {D[54:0], PIN, 1'b0}, 1'b0, 1'b0};
    rows[9] = '{8'h0f, 32'h0, {D[54:0], PIN, 1'b0}, 1'b0, 1'b0};
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    jtag_host_i.test_reset(2);
    repeat (4) @(posedge ref_clk);
    jtag_host_i.step(1'b0, 1'b0, t, oe);
    for (int i = 0; i < 10; i++) begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    // Boundary cells drive the pins after update
    check({63'h0, pin_drive}, 64'h1);
    check({56'h0, pin_out}, {56'h0, D[63:56]});
    $display("drive test done");
    // Test reset mid-run restores the identification instruction
    jtag_host_i.test_reset(3);
    @(posedge ref_clk);
    check({63'h0, pin_drive}, 64'h0);
    check({63'h0, tdo_oe_n}, 64'h1);
    repeat (4) @(posedge ref_clk);
    jtag_host_i.step(1'b0, 1'b0, t, oe);
    jtag_host_i.scan(1'b0, 64, D, q, oe);
    check(q, {ID_B, ID_C});
    $display("reset test done");
    end_of_test();
  end
endmodule

/* verilog/tap_chain.sv */
// Test port chain: pin sampling, controller state and per-tile access ports
`timescale 1ns/1ps
module tap_chain #(
  parameter int TILES = 1,
  parameter int BSR_LEN = 8,
  parameter logic [3:0] VERSION = 4'h0,
  parameter logic [15:0] PART_BSCAN = 16'h0001, // arbitrary value
  parameter logic [15:0] PART_CHIP = 16'h0002, // arbitrary value
  parameter logic [10:0] MAKER = 11'h001, // arbitrary value
  parameter logic [15:0] SIL_REV = 16'h0001 // arbitrary value
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Test pins
  input wire tap_chain_pkg::jtag_pins_t jtag,
  output logic tdo_out,
  output logic tdo_oe_n,
  // Security registers, one word per tile
  input wire logic [TILES*32-1:0] sec_reg,
  // Device pins under boundary scan
  input wire logic [TILES*BSR_LEN-1:0] pin_in,
  output logic [TILES*BSR_LEN-1:0] pin_out,
  output logic [TILES-1:0] pin_drive,
  // Tile access
  input wire logic [TILES*32-1:0] tile_rd_data,
  output logic [TILES*32-1:0] tile_wr_data,
  output logic [TILES-1:0] tile_wr_stb,
  // Programmable memory access
  input wire logic [TILES*32-1:0] otp_rd_data,
  output logic [TILES-1:0] otp_wr_stb
);
  localparam int UNITS = 2 * TILES;
  localparam logic [31:0] ID_BSCAN = {VERSION, PART_BSCAN, MAKER, 1'b1};
  localparam logic [31:0] ID_CHIP = {VERSION, PART_CHIP, MAKER, 1'b1};

  // ----------------------------------------------------------------
  // Reset: port reset while either reset is low, released on clock
  // ----------------------------------------------------------------
  wire rst_src_n = arst_n & jtag.trst_n;
  logic rst_s1_reg, rst_s2_reg;
  wire tap_rst_n = rst_s2_reg;

  always_ff @(posedge ref_clk or negedge rst_src_n) begin
    if (!rst_src_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and test clock edges
  // ----------------------------------------------------------------
  logic [2:0] s1_reg, s2_reg;
  logic tck_d_reg;

  always_ff @(posedge ref_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      tck_d_reg <= 1'b0;
    end else begin
      s1_reg <= {jtag.tck, jtag.tms, jtag.tdi};
      s2_reg <= s1_reg;
      tck_d_reg <= s2_reg[2];
    end
  end

  wire tck_rise = s2_reg[2] && !tck_d_reg;
  wire tck_fall = !s2_reg[2] && tck_d_reg;
  wire tms_s = s2_reg[1];
  wire tdi_s = s2_reg[0];

  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------
  function automatic tap_chain_pkg::tap_state_t tap_next(
    input tap_chain_pkg::tap_state_t st, input logic tms);
    case (st)
      tap_chain_pkg::ST_RESET: begin
        tap_next = tms ? tap_chain_pkg::ST_RESET : tap_chain_pkg::ST_IDLE;
      end
      tap_chain_pkg::ST_IDLE, tap_chain_pkg::ST_UPD_DR, tap_chain_pkg::ST_UPD_IR: begin
        tap_next = tms ? tap_chain_pkg::ST_SEL_DR : tap_chain_pkg::ST_IDLE;
      end
      tap_chain_pkg::ST_SEL_DR: begin
        tap_next = tms ? tap_chain_pkg::ST_SEL_IR : tap_chain_pkg::ST_CAP_DR;
      end
      tap_chain_pkg::ST_CAP_DR, tap_chain_pkg::ST_SHIFT_DR, tap_chain_pkg::ST_EXIT2_DR: begin
        tap_next = tms ? tap_chain_pkg::ST_EXIT1_DR : tap_chain_pkg::ST_SHIFT_DR;
      end
      tap_chain_pkg::ST_EXIT1_DR: begin
        tap_next = tms ? tap_chain_pkg::ST_UPD_DR : tap_chain_pkg::ST_PAUSE_DR;
      end
      tap_chain_pkg::ST_PAUSE_DR: begin
        tap_next = tms ? tap_chain_pkg::ST_EXIT2_DR : tap_chain_pkg::ST_PAUSE_DR;
      end
      tap_chain_pkg::ST_SEL_IR: begin
        tap_next = tms ? tap_chain_pkg::ST_RESET : tap_chain_pkg::ST_CAP_IR;
      end
      tap_chain_pkg::ST_CAP_IR, tap_chain_pkg::ST_SHIFT_IR, tap_chain_pkg::ST_EXIT2_IR: begin
        tap_next = tms ? tap_chain_pkg::ST_EXIT1_IR : tap_chain_pkg::ST_SHIFT_IR;
      end
      tap_chain_pkg::ST_EXIT1_IR: begin
        tap_next = tms ? tap_chain_pkg::ST_UPD_IR : tap_chain_pkg::ST_PAUSE_IR;
      end
      tap_chain_pkg::ST_PAUSE_IR: begin
        tap_next = tms ? tap_chain_pkg::ST_EXIT2_IR : tap_chain_pkg::ST_PAUSE_IR;
      end
      default: begin
        tap_next = tap_chain_pkg::ST_RESET;
      end
    endcase
  endfunction

  tap_chain_pkg::tap_state_t state_reg, state_next;
  assign state_next = tck_rise ? tap_next(state_reg, tms_s) : state_reg;

  always_ff @(posedge ref_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state_reg <= tap_chain_pkg::ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Actions happen on the rising test clock while in the state
  tap_chain_pkg::tap_step_t step;
  assign step.test_reset = tck_rise && state_reg == tap_chain_pkg::ST_RESET;
  assign step.capture_dr = tck_rise && state_reg == tap_chain_pkg::ST_CAP_DR;
  assign step.shift_dr = tck_rise && state_reg == tap_chain_pkg::ST_SHIFT_DR;
  assign step.update_dr = tck_rise && state_reg == tap_chain_pkg::ST_UPD_DR;
  assign step.capture_ir = tck_rise && state_reg == tap_chain_pkg::ST_CAP_IR;
  assign step.shift_ir = tck_rise && state_reg == tap_chain_pkg::ST_SHIFT_IR;
  assign step.update_ir = tck_rise && state_reg == tap_chain_pkg::ST_UPD_IR;
  wire in_shift = state_reg == tap_chain_pkg::ST_SHIFT_DR ||
                  state_reg == tap_chain_pkg::ST_SHIFT_IR;

  // ----------------------------------------------------------------
  // Chain: per tile a boundary port, then a chip port
  // ----------------------------------------------------------------
  logic [UNITS:0] link;
  assign link[0] = tdi_s;
  wire [9:0] user_id = sec_reg[tap_chain_pkg::SEC_USER_LSB +: tap_chain_pkg::UC_USER_W];

  genvar t;
  generate
    for (t = 0; t < TILES; t++) begin : g_tile
      tap_unit #(
        .IS_CHIP(1'b0), .BSR_LEN(BSR_LEN), .ID_VAL(ID_BSCAN), .REV_VAL(SIL_REV)
      ) u_bscan (
        .clk(ref_clk), .rst_n(tap_rst_n), .step(step),
        .si(link[2*t]), .so(link[2*t+1]),
        .sec(sec_reg[t*32 +: 32]), .user_id(user_id),
        .pin_in(pin_in[t*BSR_LEN +: BSR_LEN]),
        .pin_out(pin_out[t*BSR_LEN +: BSR_LEN]),
        .pin_drive(pin_drive[t]),
        .rd_data(32'h0000_0000), .wr_data(), .wr_stb(),
        .otp_rd(32'h0000_0000), .otp_stb()
      );
      tap_unit #(
        .IS_CHIP(1'b1), .BSR_LEN(BSR_LEN), .ID_VAL(ID_CHIP), .REV_VAL(SIL_REV)
      ) u_chip (
        .clk(ref_clk), .rst_n(tap_rst_n), .step(step),
        .si(link[2*t+1]), .so(link[2*t+2]),
        .sec(sec_reg[t*32 +: 32]), .user_id(user_id),
        .pin_in({BSR_LEN{1'b0}}), .pin_out(), .pin_drive(),
        .rd_data(tile_rd_data[t*32 +: 32]),
        .wr_data(tile_wr_data[t*32 +: 32]),
        .wr_stb(tile_wr_stb[t]),
        .otp_rd(otp_rd_data[t*32 +: 32]),
        .otp_stb(otp_wr_stb[t])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Test data out, changed on the falling test clock
  // ----------------------------------------------------------------
  logic tdo_reg, tdo_oe_n_reg;

  always_ff @(posedge ref_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo_reg <= 1'b0;
      tdo_oe_n_reg <= 1'b1;
    end else if (tck_fall) begin
      tdo_reg <= link[UNITS];
      tdo_oe_n_reg <= !in_shift;
    end
  end

  assign tdo_out = tdo_reg;
  assign tdo_oe_n = tdo_oe_n_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  held_reset_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !tap_rst_n |-> state_reg == tap_chain_pkg::ST_RESET && tdo_oe_n)
    else $error("port not held in reset");
  tck_only_a: assert property (@(posedge ref_clk) disable iff (!tap_rst_n)
    !tck_rise |=> $stable(state_reg))
    else $error("state moved without test clock");
  tdo_drive_a: assert property (@(posedge ref_clk) disable iff (!tap_rst_n)
    tck_fall && in_shift |=> !tdo_oe_n && tdo_out == $past(link[UNITS]))
    else $error("data out not driven in shift");
  tdo_idle_a: assert property (@(posedge ref_clk) disable iff (!tap_rst_n)
    tck_fall && !in_shift |=> tdo_oe_n)
    else $error("data out driven outside shift");
  tms_reset_a: assert property (@(posedge ref_clk) disable iff (!tap_rst_n)
    tck_rise && tms_s && state_reg == tap_chain_pkg::ST_SEL_IR
    |=> state_reg == tap_chain_pkg::ST_RESET)
    else $error("select ir did not return to reset");
endmodule

/* verilog/tap_chain_pkg.sv */
// Shared constants and types for the test access port chain
package tap_chain_pkg;

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  localparam int IR_LEN = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] INS_EXTEST = 4'h0;
  localparam logic [3:0] INS_DEVICE_IDENTIFICATION = 4'h1;
  localparam logic [3:0] INS_USERCODE = 4'h2;
  localparam logic [3:0] INS_SAMPLE = 4'h3;
  localparam logic [3:0] INS_TILE_ACCESS = 4'h8;
  localparam logic [3:0] INS_OTP_ACCESS = 4'h9;
  localparam logic [3:0] INS_BYPASS = 4'hf;
  localparam logic [3:0] IR_RESET = INS_DEVICE_IDENTIFICATION;

  // ----------------------------------------------------------------
  // Data register layout
  // ----------------------------------------------------------------
  localparam int DR_W = 32;
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  localparam int UC_USER_LSB = 22;
  localparam int UC_USER_W = 10;
  localparam int UC_UNUSED_W = 6;
  localparam int UC_REV_W = 16;

  // ----------------------------------------------------------------
  // Security register bits
  // ----------------------------------------------------------------
  localparam int SEC_NO_JTAG_BIT = 0;
  localparam int SEC_NO_OTP_BIT = 13;
  localparam int SEC_USER_LSB = 22;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAP_DR     = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPD_DR     = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAP_IR     = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPD_IR     = 16'h8000
  } tap_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jtag_pins_t;

  typedef struct packed {
    logic test_reset;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;
  } tap_step_t;

endpackage

/* verilog/tap_unit.sv */
// One test access port's instruction and data registers
`timescale 1ns/1ps
module tap_unit #(
  parameter bit IS_CHIP = 1'b0,
  parameter int BSR_LEN = 8,
  parameter logic [31:0] ID_VAL = 32'h0000_0001,
  parameter logic [15:0] REV_VAL = 16'h0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Chain
  input wire tap_chain_pkg::tap_step_t step,
  input wire logic si,
  output logic so,
  // Security and identity
  input wire logic [31:0] sec,
  input wire logic [9:0] user_id,
  // Boundary cells
  input wire logic [BSR_LEN-1:0] pin_in,
  output logic [BSR_LEN-1:0] pin_out,
  output logic pin_drive,
  // Tile and programmable memory access
  input wire logic [31:0] rd_data,
  output logic [31:0] wr_data,
  output logic wr_stb,
  input wire logic [31:0] otp_rd,
  output logic otp_stb
);
  localparam int SW = (BSR_LEN > 32) ? BSR_LEN : 32;
  localparam int LW = $clog2(SW + 1);

  logic [3:0] ir_sh_reg, ir_reg;
  logic ir_path_reg;
  logic [SW-1:0] dr_reg, dr_next, cap_val, shifted;
  logic [BSR_LEN-1:0] pin_out_reg;
  logic pin_drive_reg, wr_stb_reg, otp_stb_reg;
  logic [31:0] wr_data_reg;

  // ----------------------------------------------------------------
  // Register selection
  // ----------------------------------------------------------------
  wire jtag_off = sec[tap_chain_pkg::SEC_NO_JTAG_BIT];
  wire otp_off = sec[tap_chain_pkg::SEC_NO_OTP_BIT];
  wire sel_id = (ir_reg == tap_chain_pkg::INS_DEVICE_IDENTIFICATION);
  wire sel_uc = (ir_reg == tap_chain_pkg::INS_USERCODE);
  wire sel_bsr = !IS_CHIP && (ir_reg == tap_chain_pkg::INS_SAMPLE ||
                              ir_reg == tap_chain_pkg::INS_EXTEST);
  wire sel_tile = IS_CHIP && !jtag_off &&
                  ir_reg == tap_chain_pkg::INS_TILE_ACCESS;
  wire sel_otp = IS_CHIP && !jtag_off && !otp_off &&
                 ir_reg == tap_chain_pkg::INS_OTP_ACCESS;
  wire [31:0] usercode = {user_id, {tap_chain_pkg::UC_UNUSED_W{1'b0}}, REV_VAL};
  wire [LW-1:0] dr_last = sel_bsr ? LW'(BSR_LEN - 1) :
                          (sel_id || sel_uc || sel_tile || sel_otp) ? LW'(31) : LW'(0);

  assign cap_val = sel_id ? SW'(ID_VAL) :
                   sel_uc ? SW'(usercode) :
                   sel_bsr ? SW'(pin_in) :
                   sel_tile ? SW'(rd_data) :
                   sel_otp ? SW'(otp_rd) : '0;

  // Shift toward bit 0, entering at the selected length
  genvar i;
  generate
    for (i = 0; i < SW; i++) begin : g_shift
      if (i == SW - 1) begin : g_top
        assign shifted[i] = (dr_last == LW'(i)) ? si : 1'b0;
      end else begin : g_mid
        assign shifted[i] = (dr_last == LW'(i)) ? si : dr_reg[i+1];
      end
    end
  endgenerate

  assign dr_next = step.capture_dr ? cap_val : step.shift_dr ? shifted : dr_reg;
  // Serial out follows the path captured last, so it holds between shift pulses
  assign so = ir_path_reg ? ir_sh_reg[0] : dr_reg[0];
  assign pin_out = pin_out_reg;
  assign pin_drive = pin_drive_reg;
  assign wr_data = wr_data_reg;
  assign wr_stb = wr_stb_reg;
  assign otp_stb = otp_stb_reg;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_sh_reg <= tap_chain_pkg::IR_CAPTURE;
      ir_reg <= tap_chain_pkg::IR_RESET;
      dr_reg <= '0;
      ir_path_reg <= 1'b0;
    end else begin
      dr_reg <= dr_next;
      if (step.test_reset) begin
        ir_reg <= tap_chain_pkg::IR_RESET;
      end else if (step.update_ir) begin
        ir_reg <= ir_sh_reg;
      end
      if (step.capture_ir) begin
        ir_sh_reg <= tap_chain_pkg::IR_CAPTURE;
      end else if (step.shift_ir) begin
        ir_sh_reg <= {si, ir_sh_reg[3:1]};
      end
      if (step.capture_ir) begin
        ir_path_reg <= 1'b1;
      end else if (step.capture_dr || step.test_reset) begin
        ir_path_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_reg <= '0;
      pin_drive_reg <= 1'b0;
      wr_data_reg <= '0;
      wr_stb_reg <= 1'b0;
      otp_stb_reg <= 1'b0;
    end else begin
      pin_drive_reg <= !IS_CHIP && ir_reg == tap_chain_pkg::INS_EXTEST;
      if (step.update_dr && (sel_bsr || sel_tile || sel_otp)) begin
        pin_out_reg <= dr_reg[BSR_LEN-1:0];
        wr_data_reg <= dr_reg[31:0];
      end
      wr_stb_reg <= step.update_dr && sel_tile;
      otp_stb_reg <= step.update_dr && sel_otp;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence id_captured;
    step.capture_dr && sel_id;
  endsequence

  device_identification_capture_a: assert property (id_captured |=> dr_reg[31:0] == ID_VAL && dr_reg[0])
    else $error("identification value not captured");
  usercode_capture_a: assert property (step.capture_dr && sel_uc |=>
    dr_reg[31:22] == $past(user_id) && dr_reg[21:16] == 6'h00)
    else $error("user code value not captured");
  sequence id_shifting;
    step.shift_dr && sel_id;
  endsequence

  id_shift_lsb_a: assert property (id_shifting |=>
    dr_reg[30:0] == $past(dr_reg[31:1]) && dr_reg[31] == $past(si))
    else $error("identification not shifted lsb first");
  ir_out_a: assert property (step.shift_ir |-> so == ir_sh_reg[0])
    else $error("instruction bits not on serial out");
  tile_lock_a: assert property (step.update_dr && jtag_off |=> !wr_stb && !otp_stb)
    else $error("tile access while locked");
  otp_lock_a: assert property (step.update_dr && otp_off |=> !otp_stb)
    else $error("memory access while locked");
  tile_write_a: assert property (step.update_dr && IS_CHIP && !jtag_off &&
    ir_reg == tap_chain_pkg::INS_TILE_ACCESS |=> wr_stb && wr_data == $past(dr_reg[31:0]))
    else $error("tile write not issued");
  extest_drive_a: assert property (ir_reg == tap_chain_pkg::INS_EXTEST && !IS_CHIP
    |=> pin_drive)
    else $error("boundary cells not driving");
endmodule
